// ==== rtl/osc_switch_pkg.sv ====
/*
 * constants, register map and carrier types for the run-mode clock switch.
 * assumes a 25 MHz system clock and a single AHB-Lite master on the bus.
 */
package osc_switch_pkg;

   // ***************************************************
   // register byte offsets
   // ***************************************************
   localparam logic [11:0] OFS_OSC_CTRL = 12'h000;   // control and flags
   localparam logic [11:0] OFS_CMD      = 12'h004;   // sleep command strobe
   localparam logic [11:0] OFS_CFG      = 12'h008;   // watchdog / monitor enables
   localparam logic [11:0] OFS_STATUS   = 12'h00C;   // run state, read only

   // ***************************************************
   // field positions and reset values
   // ***************************************************
   localparam int          CMD_SLEEP_BIT  = 0;          // write 1 executes sleep
   localparam int          CFG_WDT_BIT    = 0;          // watchdog enable
   localparam int          CFG_FSCM_BIT   = 1;          // fail-safe monitor enable
   localparam logic [7:0]  OSC_CTRL_RESET = 8'h08;      // primary running after reset
   localparam logic [1:0]  CFG_RESET      = 2'h0;       // both monitors off
   localparam logic [31:0] READ_ZERO      = 32'h0000_0000;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int SYS_CLK_MHZ         = 25;                            // system clock rate
   localparam int STABILISE_TIME_US   = 1000;                          // fast source settling
   localparam int STABILISE_CYCLES    = STABILISE_TIME_US * SYS_CLK_MHZ;
   localparam int SWITCH_DELAY_CYCLES = 4;                             // dead time between gates

   // ***************************************************
   // types
   // ***************************************************
   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       idle_on_sleep_select;
      logic [2:0] internal_freq_select;
      logic       primary_clock_running_flag;
      logic       internal_freq_stable_flag;
      logic [1:0] sys_clk_select;
   } osc_ctrl_t;

   // system clock gates, at most one high at a time
   typedef struct packed {
      logic primary;
      logic internal;
   } clk_gate_t;

   // run mode sequencer
   typedef enum {
      ST_PRIMARY_RUN,
      ST_ENTER_SWITCH,
      ST_INTERNAL_RUN,
      ST_WAKE_RESTART,
      ST_EXIT_SWITCH
   } run_state_t;

endpackage

// ==== rtl/osc_stabilise_timer.sv ====
/*
 * settling timer for the fast internal source: one pulse after the source
 * has been enabled for CYCLES clocks.
 * assumes enable is a registered level on the same clock.
 */
`timescale 1ns/1ps
module osc_stabilise_timer #(
   parameter int CYCLES = 25000
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic enable,
   output logic      done_pulse
);
   localparam int            CNT_W = $clog2(CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST  = CNT_W'(CYCLES - 1);

   logic [CNT_W-1:0] cnt_q;     // cycles since enable rose
   logic [CNT_W-1:0] cnt_d;
   logic             pulse_q;   // registered done pulse
   logic             pulse_d;

   // ***************************************************
   // count while enabled, restart from zero when off
   // ***************************************************
   always_comb begin
      cnt_d   = cnt_q;
      pulse_d = 1'b0;
      if (!enable) begin
         cnt_d = '0;   // source off, settling starts over
      end else if (cnt_q <= LAST) begin
         cnt_d   = cnt_q + 1'b1;
         pulse_d = (cnt_q == LAST);   // fires exactly once per enable
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_q   <= '0;
         pulse_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

   assign done_pulse = pulse_q;
endmodule

// ==== rtl/glitch_free_clock_switch.sv ====
/*
 * break-before-make selector for the two system clock gates.
 * assumes sel_internal is a level on the system clock; the gates drive
 * clock-gating cells downstream, so a gate only rises when both are low.
 */
`timescale 1ns/1ps
module glitch_free_clock_switch
   import osc_switch_pkg::*;
#(
   parameter int GAP = 4
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic sel_internal,
   output clk_gate_t gate,
   output logic      switch_done
);
   localparam int           GW      = $clog2(GAP + 1);
   localparam logic [GW-1:0] GAP_CNT = GW'(GAP);

   clk_gate_t       gate_q;   // current gates
   clk_gate_t       gate_d;
   logic            cur_q;    // side last enabled, 1 = internal
   logic            cur_d;
   logic [GW-1:0]   cnt_q;    // dead-time countdown
   logic [GW-1:0]   cnt_d;

   // ***************************************************
   // old gate off, wait, then new gate on
   // ***************************************************
   always_comb begin
      gate_d = gate_q;
      cur_d  = cur_q;
      cnt_d  = cnt_q;
      if (gate_q == '0) begin
         // both low: safe to pick whichever side is wanted now
         if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
         end else begin
            cur_d           = sel_internal;
            gate_d.internal = sel_internal;
            gate_d.primary  = !sel_internal;
         end
      end else if (cur_q != sel_internal) begin
         gate_d = '0;        // stop old clock low first
         cnt_d  = GAP_CNT;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         gate_q <= '{primary: 1'b1, internal: 1'b0};
         cur_q  <= 1'b0;
         cnt_q  <= '0;
      end else begin
         gate_q <= gate_d;
         cur_q  <= cur_d;
         cnt_q  <= cnt_d;
      end
   end

   assign gate        = gate_q;
   assign switch_done = (cur_q == sel_internal) && (gate_q != '0);
endmodule

// ==== rtl/internal_osc_run_mode_clock_switch.sv ====
/*
 * run-mode clock source controller: AHB-Lite register slave, entry to and
 * exit from the internal oscillator run mode, stable/running flags and
 * oscillator enables.
 * assumes one AHB-Lite master, word accesses only, and that the wake and
 * primary-ready pins are asynchronous to sys_clk.
 */
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module internal_osc_run_mode_clock_switch #(
   parameter int STABILISE_CYCLES = osc_switch_pkg::STABILISE_CYCLES
) (
   input  wire logic                sys_clk,
   input  wire logic                reset,
   // ahb-lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic [31:0]              hrdata,
   output logic                     hresp,
   // asynchronous events
   input  wire logic                wake_event_pin,
   input  wire logic                primary_ready_pin,
   // oscillator and clock-tree controls
   output logic                     primary_osc_enable,
   output logic                     fast_osc_enable,
   output logic [2:0]               fast_osc_freq,
   output logic                     slow_osc_enable,
   output osc_switch_pkg::clk_gate_t sys_clk_gate
);
   import osc_switch_pkg::*;

   // ***************************************************
   // declarations
   // ***************************************************
   logic [1:0]  wake_sync_q;      // bit 0 first stage, bit 1 second
   logic [1:0]  ready_sync_q;     // same arrangement
   logic        wake_evt;         // synchronised wake level
   logic        primary_ready;    // synchronised ready level

   logic        accept;           // address phase taken this edge
   logic        wr_pend_q;        // write data phase pending
   logic        wr_pend_d;
   logic [11:0] wr_addr_q;        // captured write offset
   logic [11:0] wr_addr_d;
   logic [31:0] hrdata_q;         // read data, loaded in address phase
   logic [31:0] hrdata_d;
   logic        hreadyout_q;      // zero wait state slave
   logic        hresp_q;          // always okay

   osc_ctrl_t   ctrl_q;           // software bits of the control register
   osc_ctrl_t   ctrl_d;
   osc_ctrl_t   ctrl_wr;          // write data viewed as control layout
   logic [1:0]  cfg_q;            // watchdog and monitor enables
   logic [1:0]  cfg_d;
   logic        sleep_cmd;        // one-cycle sleep instruction

   run_state_t  state_q;          // run mode sequencer
   run_state_t  state_d;
   logic        run_flag_q;       // primary clock running flag
   logic        run_flag_d;
   logic        stable_flag_q;    // fast source stable flag
   logic        stable_flag_d;
   logic        prim_en_q;        // primary oscillator enable
   logic        prim_en_d;
   logic        fast_en_q;        // fast internal oscillator enable
   logic        fast_en_d;
   logic        slow_en_q;        // slow internal oscillator enable
   logic        slow_en_d;
   logic [2:0]  freq_q;           // frequency driven to the oscillator
   logic [2:0]  freq_d;

   logic        sel_internal;     // wanted side of the clock switch
   logic        switch_done;      // switch settled on wanted side
   logic        stab_done;        // fast source has settled
   logic [7:0]  ctrl_view;        // control register as read back
   logic [31:0] read_mux;         // read data for the addressed register

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   // two flops per pin; only the second stage is read
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wake_sync_q  <= 2'h0;
         ready_sync_q <= 2'h0;
      end else begin
         wake_sync_q  <= {wake_sync_q[0], wake_event_pin};
         ready_sync_q <= {ready_sync_q[0], primary_ready_pin};
      end
   end

   assign wake_evt      = wake_sync_q[1];
   assign primary_ready = ready_sync_q[1];

   // ***************************************************
   // ahb-lite slave
   // ***************************************************
   // read back: software bits plus the two hardware flags
   always_comb begin
      ctrl_view = ctrl_q;
      ctrl_view[3] = run_flag_q;
      ctrl_view[2] = stable_flag_q;
   end

   // read decode; unmapped offsets read zero
   always_comb begin
      read_mux = READ_ZERO;
      case (haddr[11:0])
         OFS_OSC_CTRL: begin
            read_mux[7:0] = ctrl_view;
         end
         OFS_CFG: begin
            read_mux[1:0] = cfg_q;
         end
         OFS_STATUS: begin
            read_mux[0] = (state_q == ST_INTERNAL_RUN);
            read_mux[1] = (state_q == ST_ENTER_SWITCH) || (state_q == ST_EXIT_SWITCH);
            read_mux[2] = (state_q == ST_WAKE_RESTART);
         end
         default: begin
            read_mux = READ_ZERO;   // command register reads zero too
         end
      endcase
   end

   // address phase capture; read data is ready for the data phase
   always_comb begin
      accept    = hsel && htrans[1] && hready;
      wr_pend_d = accept && hwrite;
      wr_addr_d = wr_addr_q;
      hrdata_d  = hrdata_q;
      if (accept) begin
         wr_addr_d = haddr[11:0];
         if (!hwrite) begin
            hrdata_d = read_mux;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_pend_q   <= 1'b0;
         wr_addr_q   <= 12'h000;
         hrdata_q    <= READ_ZERO;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         wr_pend_q   <= wr_pend_d;
         wr_addr_q   <= wr_addr_d;
         hrdata_q    <= hrdata_d;
         hreadyout_q <= 1'b1;   // never stretches a transfer
         hresp_q     <= 1'b0;
      end
   end

   // ***************************************************
   // register writes
   // ***************************************************
   // the flag bits are read only; only software changes idle, frequency
   // and select, so the sequencer never touches them
   always_comb begin
      ctrl_wr   = osc_ctrl_t'(hwdata[7:0]);
      ctrl_d    = ctrl_q;
      cfg_d     = cfg_q;
      sleep_cmd = 1'b0;
      if (wr_pend_q) begin
         case (wr_addr_q)
            OFS_OSC_CTRL: begin
               ctrl_d.idle_on_sleep_select = ctrl_wr.idle_on_sleep_select;
               ctrl_d.internal_freq_select = ctrl_wr.internal_freq_select;
               ctrl_d.sys_clk_select       = ctrl_wr.sys_clk_select;
            end
            OFS_CMD: begin
               sleep_cmd = hwdata[CMD_SLEEP_BIT];
            end
            OFS_CFG: begin
               cfg_d[CFG_WDT_BIT]  = hwdata[CFG_WDT_BIT];
               cfg_d[CFG_FSCM_BIT] = hwdata[CFG_FSCM_BIT];
            end
            default: begin
               cfg_d = cfg_q;   // unmapped writes are dropped
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ctrl_q <= osc_ctrl_t'(OSC_CTRL_RESET);
         cfg_q  <= CFG_RESET;
      end else begin
         ctrl_q <= ctrl_d;
         cfg_q  <= cfg_d;
      end
   end

   // ***************************************************
   // run mode sequencer
   // ***************************************************
   // the switch sub-block owns the dead time, so entry and exit both
   // wait for switch_done rather than a fixed count
   always_comb begin
      state_d       = state_q;
      run_flag_d    = run_flag_q;
      prim_en_d     = prim_en_q;
      stable_flag_d = stable_flag_q;
      // fast source follows the field at once, in any mode
      fast_en_d     = (ctrl_q.internal_freq_select != 3'h0);
      freq_d        = ctrl_q.internal_freq_select;
      if (!fast_en_q) begin
         stable_flag_d = 1'b0;
      end
      case (state_q)
         ST_PRIMARY_RUN: begin
            // select low bit does not matter, only the high one
            if (sleep_cmd && !ctrl_q.idle_on_sleep_select && ctrl_q.sys_clk_select[1]) begin
               state_d = ST_ENTER_SWITCH;
            end
         end
         ST_ENTER_SWITCH: begin
            if (switch_done) begin
               state_d    = ST_INTERNAL_RUN;
               prim_en_d  = 1'b0;
               run_flag_d = 1'b0;
            end
         end
         ST_INTERNAL_RUN: begin
            if (wake_evt) begin
               state_d   = ST_WAKE_RESTART;
               prim_en_d = 1'b1;
            end
         end
         ST_WAKE_RESTART: begin
            if (primary_ready) begin
               state_d = ST_EXIT_SWITCH;
            end
         end
         ST_EXIT_SWITCH: begin
            if (switch_done) begin
               state_d       = ST_PRIMARY_RUN;
               run_flag_d    = 1'b1;
               stable_flag_d = 1'b0;
            end
         end
         default: begin
            state_d = ST_PRIMARY_RUN;
         end
      endcase
      // settling event wins over either clear; sleep leaves it alone
      if (stab_done) begin
         stable_flag_d = 1'b1;
      end
      // slow source feeds the internal mux at zero frequency, and stays on
      // for the watchdog or the monitor
      slow_en_d = cfg_q[CFG_WDT_BIT] || cfg_q[CFG_FSCM_BIT]
                  || (sel_internal && !fast_en_d);
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q       <= ST_PRIMARY_RUN;
         run_flag_q    <= 1'b1;
         stable_flag_q <= 1'b0;
         prim_en_q     <= 1'b1;
         fast_en_q     <= 1'b0;
         slow_en_q     <= 1'b0;
         freq_q        <= 3'h0;
      end else begin
         state_q       <= state_d;
         run_flag_q    <= run_flag_d;
         stable_flag_q <= stable_flag_d;
         prim_en_q     <= prim_en_d;
         fast_en_q     <= fast_en_d;
         slow_en_q     <= slow_en_d;
         freq_q        <= freq_d;
      end
   end

   // internal side is held from entry until the exit switch starts
   assign sel_internal = (state_q == ST_ENTER_SWITCH) || (state_q == ST_INTERNAL_RUN)
                         || (state_q == ST_WAKE_RESTART);

   // ***************************************************
   // sub-blocks
   // ***************************************************
   glitch_free_clock_switch #(
      .GAP          (SWITCH_DELAY_CYCLES)
   ) u_switch (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .sel_internal (sel_internal),
      .gate         (sys_clk_gate),
      .switch_done  (switch_done)
   );

   osc_stabilise_timer #(
      .CYCLES       (STABILISE_CYCLES)
   ) u_stabilise (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .enable       (fast_en_q),
      .done_pulse   (stab_done)
   );

   // ***************************************************
   // outputs, all from flops
   // ***************************************************
   assign hreadyout          = hreadyout_q;
   assign hrdata             = hrdata_q;
   assign hresp              = hresp_q;
   assign primary_osc_enable = prim_en_q;
   assign fast_osc_enable    = fast_en_q;
   assign fast_osc_freq      = freq_q;
   assign slow_osc_enable    = slow_en_q;
endmodule

// ==== dv/osc_switch_sva.sv ====
/*
 * assertions for the run-mode clock switch, bound to its top module.
 * assumes the bus hready is tied to the slave's own hreadyout.
 */
`timescale 1ns/1ps
module osc_switch_sva #(
   parameter int STABILISE_CYCLES = 25000
) (
   input wire logic                       sys_clk,
   input wire logic                       reset,
   input wire logic                       hreadyout,
   input wire logic                       hresp,
   input wire logic                       primary_osc_enable,
   input wire logic                       fast_osc_enable,
   input wire logic [2:0]                 fast_osc_freq,
   input wire logic                       slow_osc_enable,
   input wire osc_switch_pkg::clk_gate_t  sys_clk_gate
);
   import osc_switch_pkg::*;
   // ***************************************************
   // one domain, so one clock and one disable for all
   // ***************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   gates_exclusive_a: assert property (!(sys_clk_gate.primary && sys_clk_gate.internal))
      else $error("both clock gates high");
   int_dead_time_a: assert property ($rose(sys_clk_gate.internal) |->
      $past(sys_clk_gate, 1) == 2'h0 && $past(sys_clk_gate, 5) == 2'h0)
      else $error("internal gate rose without dead time");
   pri_dead_time_a: assert property ($rose(sys_clk_gate.primary) |->
      $past(sys_clk_gate, 1) == 2'h0 && $past(sys_clk_gate, 5) == 2'h0)
      else $error("primary gate rose without dead time");
   pri_off_internal_a: assert property (!primary_osc_enable |-> sys_clk_gate.internal)
      else $error("primary stopped while not on internal clock");
   pri_stops_late_a: assert property ($fell(primary_osc_enable) |-> $past(sys_clk_gate.internal))
      else $error("primary stopped before the switch");
   pri_gate_osc_a: assert property (sys_clk_gate.primary |-> primary_osc_enable)
      else $error("primary gate open with primary stopped");
   restart_first_a: assert property ($rose(sys_clk_gate.primary) |-> $past(primary_osc_enable, 6))
      else $error("primary not restarted before switch back");
   fast_follow_a: assert property (fast_osc_enable == (fast_osc_freq != 3'h0))
      else $error("fast enable disagrees with frequency");
   slow_on_zero_a: assert property ($rose(sys_clk_gate.internal) && fast_osc_freq == 3'h0
      |-> slow_osc_enable)
      else $error("slow source off while it clocks the system");
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or errored");
endmodule

bind internal_osc_run_mode_clock_switch osc_switch_sva #(.STABILISE_CYCLES(STABILISE_CYCLES)) u_osc_switch_sva (
   .sys_clk(sys_clk), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
   .primary_osc_enable(primary_osc_enable), .fast_osc_enable(fast_osc_enable),
   .fast_osc_freq(fast_osc_freq), .slow_osc_enable(slow_osc_enable), .sys_clk_gate(sys_clk_gate));

// ==== dv/tb_top.sv ====
/*
 * self-checking bench for the run-mode clock switch: register traffic,
 * mode entry, live frequency change, wake and switch back.
 * assumes zero-wait bus answers and the checker bound to the design.
 */
`timescale 1ns/1ps
module tb_top;
   import osc_switch_pkg::*;
   logic        sys_clk = 1'b0;
   logic        reset = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic        hreadyout;
   logic [31:0] hrdata;
   logic        hresp;
   logic        wake_event_pin = 1'b0;
   logic        primary_ready_pin = 1'b1;
   logic        primary_osc_enable;
   logic        fast_osc_enable;
   logic [2:0]  fast_osc_freq;
   logic        slow_osc_enable;
   clk_gate_t   sys_clk_gate;
   logic        rd_dph = 1'b0;  // a read data phase ends at the next edge
   logic [31:0] exp_q[$];       // expected read data, oldest first
   int          mismatches = 0;
   int          n_compared = 0;
   logic [2:0]  fr;             // random nonzero frequency code

   initial begin
      forever #20 sys_clk = ~sys_clk;
   end

   // short settling count keeps the run brief
   internal_osc_run_mode_clock_switch #(.STABILISE_CYCLES(20)) u_internal_osc_run_mode_clock_switch (
      .sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .wake_event_pin(wake_event_pin),
      .primary_ready_pin(primary_ready_pin), .primary_osc_enable(primary_osc_enable),
      .fast_osc_enable(fast_osc_enable), .fast_osc_freq(fast_osc_freq),
      .slow_osc_enable(slow_osc_enable), .sys_clk_gate(sys_clk_gate));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (mismatches == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] f, input logic [1:0] fl, input logic [1:0] sel);
      return {24'h00_0000, 1'b0, f, fl, sel};
   endfunction

   // one single word; for a read, d is the value expected back
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {20'h0_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      if (!wr) begin
         exp_q.push_back(d);
      end
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) begin
         @(posedge sys_clk);
      end
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_dph <= !wr;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) begin
         @(posedge sys_clk);
      end
      rd_dph <= 1'b0;
   endtask

   // bounded wait for one gate alone to be open; the dead time with both
   // gates low is not an end point, so wait for the whole gate value
   task automatic wait_gate(input logic want_int);
      int          n;
      logic [31:0] want;
      n    = 0;
      want = want_int ? 32'h0000_0001 : 32'h0000_0002;
      while (32'(sys_clk_gate) !== want && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      check(32'(sys_clk_gate), want);
   endtask

   // sleep, then see the system land on the internal clock
   task automatic enter();
      bus(1'b1, OFS_CMD, 32'h0000_0001);
      primary_ready_pin <= 1'b0;
      wait_gate(1'b1);
      repeat (2) @(posedge sys_clk);
      check(32'(primary_osc_enable), 32'h0000_0000);
      bus(1'b0, OFS_STATUS, 32'h0000_0001);
   endtask

   // wake, let the primary come ready, see the switch back
   task automatic wake_back(input logic [31:0] exp_ctl);
      wake_event_pin <= 1'b1;
      repeat (8) @(posedge sys_clk);
      check(32'(primary_osc_enable), 32'h0000_0001);
      check(32'(sys_clk_gate), 32'h0000_0001);
      bus(1'b0, OFS_STATUS, 32'h0000_0004);
      primary_ready_pin <= 1'b1;
      wait_gate(1'b0);
      repeat (2) @(posedge sys_clk);
      wake_event_pin <= 1'b0;
      bus(1'b0, OFS_OSC_CTRL, exp_ctl);
      check(32'(slow_osc_enable), 32'h0000_0001);
   endtask

   // results are compared as their data phases end
   always @(posedge sys_clk) begin
      if (rd_dph && hreadyout === 1'b1) begin
         check(hrdata, exp_q.pop_front());
      end
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      mismatches++;
      close_out();
   end

   initial begin
      void'($urandom(32'h3fd8955f));
      fr = 3'($urandom_range(7, 1));
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      bus(1'b0, OFS_OSC_CTRL, {24'h00_0000, OSC_CTRL_RESET});
      bus(1'b0, OFS_CFG, 32'h0000_0000);
      bus(1'b0, OFS_STATUS, 32'h0000_0000);
      bus(1'b1, 12'h010, $urandom);
      bus(1'b0, 12'h010, READ_ZERO);
      // sleep must not switch with idle select set or only the low select bit
      bus(1'b1, OFS_OSC_CTRL, 32'h0000_0082);
      bus(1'b1, OFS_CMD, 32'h0000_0001);
      bus(1'b1, OFS_OSC_CTRL, ctl(3'h0, 2'h0, 2'h1));
      bus(1'b1, OFS_CMD, 32'h0000_0001);
      repeat (10) @(posedge sys_clk);
      check(32'(sys_clk_gate), 32'h0000_0002);
      // a wake outside the internal run mode changes nothing
      wake_event_pin <= 1'b1;
      repeat (20) @(posedge sys_clk);
      check(32'(sys_clk_gate), 32'h0000_0002);
      wake_event_pin <= 1'b0;
      // zero frequency entry, low select bit set but ignored
      bus(1'b1, OFS_OSC_CTRL, ctl(3'h0, 2'h0, 2'h3));
      enter();
      check(32'(slow_osc_enable), 32'h0000_0001);
      bus(1'b0, OFS_OSC_CTRL, ctl(3'h0, 2'h0, 2'h3));
      // live frequency change while on the internal clock
      bus(1'b1, OFS_OSC_CTRL, ctl(fr, 2'h0, 2'h3));
      repeat (2) @(posedge sys_clk);
      check(32'(fast_osc_freq), 32'(fr));
      check(32'(fast_osc_enable), 32'h0000_0001);
      bus(1'b0, OFS_OSC_CTRL, ctl(fr, 2'h0, 2'h3));
      repeat (30) @(posedge sys_clk);
      bus(1'b0, OFS_OSC_CTRL, ctl(fr, 2'h1, 2'h3));
      bus(1'b1, OFS_CFG, 32'h0000_0002);
      wake_back(ctl(fr, 2'h2, 2'h3));
      // stable before sleep stays stable; watchdog keeps slow source
      bus(1'b1, OFS_CFG, 32'h0000_0001);
      bus(1'b1, OFS_OSC_CTRL, ctl(3'h0, 2'h0, 2'h2));
      bus(1'b1, OFS_OSC_CTRL, ctl(fr, 2'h0, 2'h2));
      repeat (30) @(posedge sys_clk);
      enter();
      check(32'(fast_osc_freq), 32'(fr));
      bus(1'b0, OFS_OSC_CTRL, ctl(fr, 2'h1, 2'h2));
      wake_back(ctl(fr, 2'h2, 2'h2));
      close_out();
   end
endmodule
